// File: logic/bsafe_core.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - a 16- or 8-bit target gets the word as several successive bus cycles.
// - both width inputs are sampled on every clock edge.
// - width is taken from inputs sampled the clock before ready; target holds them.
// - width inputs are active low; undriven high means full 32-bit width.
// - while mask input is low, address bit 20 is forced low for lookup and bus.
// - the address mask input is asynchronous and synchronised internally.
// - an unmasked floating-point error drives the fault output low.
// - a masked floating-point error class never drives the fault output.
// - the fault output stays driven while the bus is held by another master.
// - the fault output still asserts while the ignore-error input is low.
module bsafe_core (
   input  wire logic                             aclk,
   input  wire logic                             aresetn,
   // axi4-lite slave
   input  wire logic [bsafe_pkg::AXI_AW-1:0]     s_axi_awaddr,
   input  wire logic                             s_axi_awvalid,
   output logic                                  s_axi_awready,
   input  wire logic [bsafe_pkg::DATA_W-1:0]     s_axi_wdata,
   input  wire logic [3:0]                       s_axi_wstrb,
   input  wire logic                             s_axi_wvalid,
   output logic                                  s_axi_wready,
   output logic [1:0]                            s_axi_bresp,
   output logic                                  s_axi_bvalid,
   input  wire logic                             s_axi_bready,
   input  wire logic [bsafe_pkg::AXI_AW-1:0]     s_axi_araddr,
   input  wire logic                             s_axi_arvalid,
   output logic                                  s_axi_arready,
   output logic [bsafe_pkg::DATA_W-1:0]          s_axi_rdata,
   output logic [1:0]                            s_axi_rresp,
   output logic                                  s_axi_rvalid,
   input  wire logic                             s_axi_rready,
   output logic                                  irq,
   // core request side
   input  wire logic                             req_valid,
   output logic                                  req_ready,
   input  wire logic [bsafe_pkg::ADDR_W-1:0]     req_addr,
   input  wire logic                             req_write,
   input  wire logic [bsafe_pkg::DATA_W-1:0]     req_wdata,
   output logic                                  resp_valid,
   output logic [bsafe_pkg::DATA_W-1:0]          resp_rdata,
   output logic                                  lookup_valid,
   output logic [bsafe_pkg::ADDR_W-1:0]          lookup_addr,
   // external bus
   output logic                                  bus_start_n,
   output logic [bsafe_pkg::ADDR_W-1:0]          bus_addr,
   output logic [3:0]                            bus_byte_en_n,
   output logic                                  bus_write,
   output logic [bsafe_pkg::DATA_W-1:0]          bus_wdata,
   input  wire logic [bsafe_pkg::DATA_W-1:0]     bus_rdata,
   input  wire logic                             burst_cycle_done_n,
   input  wire logic                             width16_req_n,
   input  wire logic                             width8_req_n,
   input  wire logic                             addr_bit20_force_low_n,
   input  wire logic                             bus_hold,
   // numeric error side
   input  wire logic                             fp_error_valid,
   input  wire logic [bsafe_pkg::FP_CLS_W-1:0]   fp_error_class,
   input  wire logic                             fp_error_clear,
   input  wire logic                             fp_fault_ignore_n,
   output logic                                  fp_fault_out_n
);
   import bsafe_pkg::*;

   bsafe_state_type           state_reg;
   logic [1:0]                width_pins_reg;
   logic                      a20_meta_reg;
   logic                      a20_sync_reg;
   logic [ADDR_W-1:0]         raw_addr_reg;
   logic [2:0]                offset_reg;
   logic [1:0]                width_code_reg;
   logic                      split_seen_reg;
   logic [FP_CLS_W-1:0]       fp_mask_reg;
   logic [IRQ_W-1:0]          irq_stat_reg;
   logic [IRQ_W-1:0]          irq_mask_reg;
   logic [AXI_AW-1:0]         aw_addr_reg;
   logic [DATA_W-1:0]         w_data_reg;
   logic [3:0]                w_strb_reg;
   logic                      aw_full_reg;
   logic                      w_full_reg;
   logic [2:0]                xfer_bytes;
   logic [2:0]                next_offset;
   logic                      bus_ready;
   logic                      fp_unmasked;
   logic                      fault_set_next;
   logic                      wr_fire;
   logic [IRQ_W-1:0]          irq_events;
   logic [IRQ_W-1:0]          irq_stat_next;
   logic [DATA_W-1:0]         status_word;

   // address with bit 20 forced low while the synchronised mask is active
   function automatic logic [ADDR_W-1:0] mask_a20(input logic [ADDR_W-1:0] a, input logic force_n);
      logic [ADDR_W-1:0] m;
      m = a;
      if (!force_n) begin
         m[A20_BIT] = 1'b0;
      end
      return m;
   endfunction

   // width pins sampled every edge, no matter what the bus is doing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         width_pins_reg <= 2'h3;
      end else begin
         width_pins_reg <= {width16_req_n, width8_req_n};
      end
   end

   // two-flop synchroniser for the asynchronous mask pin
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         a20_meta_reg <= A20_SYNC_RST;
         a20_sync_reg <= A20_SYNC_RST;
      end else begin
         a20_meta_reg <= addr_bit20_force_low_n;
         a20_sync_reg <= a20_meta_reg;
      end
   end

   // size of the current cycle from the pins of the clock before ready
   always_comb begin
      if (!width_pins_reg[0]) begin
         xfer_bytes = BYTES_8;    // narrower wins, active low
      end else if (!width_pins_reg[1]) begin
         xfer_bytes = BYTES_16;
      end else begin
         xfer_bytes = WORD_BYTES; // pulled-up pins mean full width
      end
   end

   assign next_offset = offset_reg + xfer_bytes;
   assign bus_ready   = (state_reg == ST_DATA) && !burst_cycle_done_n;

   // bus sequencer: one request becomes one to four bus cycles
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg      <= ST_IDLE;
         req_ready      <= 1'b1;
         resp_valid     <= 1'b0;
         resp_rdata     <= 32'h0000_0000;
         lookup_valid   <= 1'b0;
         lookup_addr    <= 32'h0000_0000;
         bus_start_n    <= 1'b1;
         bus_addr       <= 32'h0000_0000;
         bus_byte_en_n  <= 4'hF;
         bus_write      <= 1'b0;
         bus_wdata      <= 32'h0000_0000;
         raw_addr_reg   <= 32'h0000_0000;
         offset_reg     <= 3'h0;
         width_code_reg <= 2'h3;
         split_seen_reg <= 1'b0;
      end else begin
         resp_valid   <= 1'b0;
         lookup_valid <= 1'b0;
         unique case (state_reg)
            ST_IDLE: begin
               if (req_valid && req_ready) begin
                  req_ready      <= 1'b0;
                  raw_addr_reg   <= req_addr;
                  lookup_addr    <= mask_a20(req_addr, a20_sync_reg);
                  lookup_valid   <= 1'b1;
                  bus_addr       <= mask_a20({req_addr[ADDR_W-1:2], 2'h0}, a20_sync_reg);
                  bus_byte_en_n  <= 4'h0;
                  bus_write      <= req_write;
                  bus_wdata      <= req_wdata;
                  bus_start_n    <= 1'b0;
                  offset_reg     <= 3'h0;
                  split_seen_reg <= 1'b0;
                  state_reg      <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               bus_start_n <= 1'b1;
               state_reg   <= ST_DATA;
            end
            ST_DATA: begin
               if (bus_ready) begin
                  width_code_reg <= width_pins_reg;
                  for (int i = 0; i < 4; i++) begin
                     if (i >= offset_reg && i < next_offset) begin
                        resp_rdata[8*i +: 8] <= bus_rdata[8*i +: 8];
                     end
                  end
                  if (next_offset >= WORD_BYTES) begin
                     resp_valid    <= 1'b1;
                     req_ready     <= 1'b1;
                     bus_byte_en_n <= 4'hF;
                     state_reg     <= ST_IDLE;
                  end else begin
                     // narrow target: run another cycle for the bytes left
                     split_seen_reg <= 1'b1;
                     offset_reg     <= next_offset;
                     bus_byte_en_n  <= ~(4'hF << next_offset[1:0]);
                     bus_addr       <= mask_a20({raw_addr_reg[ADDR_W-1:2], next_offset[1:0]},
                                                a20_sync_reg);
                     bus_start_n    <= 1'b0;
                     state_reg      <= ST_ADDR;
                  end
               end
            end
         endcase
      end
   end

   // numeric fault output; set wins over clear, bus hold has no say
   assign fp_unmasked    = fp_error_valid && ((fp_error_class & ~fp_mask_reg) != '0);
   assign fault_set_next = fp_unmasked; // ignore input not consulted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fp_fault_out_n <= 1'b1;
      end else if (fault_set_next) begin
         fp_fault_out_n <= 1'b0;
      end else if (fp_error_clear) begin
         fp_fault_out_n <= 1'b1;
      end
   end

   // interrupt status: sticky, write one to clear, event beats clear
   assign irq_events[IRQ_FP_BIT]    = fault_set_next;
   assign irq_events[IRQ_SPLIT_BIT] = bus_ready && (next_offset >= WORD_BYTES) &&
                                      (split_seen_reg || xfer_bytes != WORD_BYTES);
   assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
   always_comb begin
      irq_stat_next = irq_stat_reg;
      if (wr_fire && aw_addr_reg == REG_IRQ_STAT && w_strb_reg[0]) begin
         irq_stat_next = irq_stat_reg & ~w_data_reg[IRQ_W-1:0];
      end
      irq_stat_next = irq_stat_next | irq_events;
   end

   // software registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fp_mask_reg  <= FP_MASK_RST;
         irq_mask_reg <= IRQ_MASK_RST;
         irq_stat_reg <= '0;
         irq          <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq          <= |(irq_stat_reg & irq_mask_reg);
         if (wr_fire && w_strb_reg[0]) begin
            if (aw_addr_reg == REG_FP_MASK) begin
               fp_mask_reg <= w_data_reg[FP_CLS_W-1:0];
            end
            if (aw_addr_reg == REG_IRQ_MASK) begin
               irq_mask_reg <= w_data_reg[IRQ_W-1:0];
            end
         end
      end
   end

   // axi write path: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= AXI_OKAY;
         aw_full_reg   <= 1'b0;
         w_full_reg    <= 1'b0;
         aw_addr_reg   <= '0;
         w_data_reg    <= 32'h0000_0000;
         w_strb_reg    <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_reg   <= s_axi_awaddr;
            aw_full_reg   <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_reg   <= s_axi_wdata;
            w_strb_reg   <= s_axi_wstrb;
            w_full_reg   <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_reg == REG_FP_MASK || aw_addr_reg == REG_STATUS ||
                             aw_addr_reg == REG_IRQ_STAT || aw_addr_reg == REG_IRQ_MASK)
                            ? AXI_OKAY : AXI_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_full_reg   <= 1'b0;
            w_full_reg    <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // live state seen by software
   always_comb begin
      status_word                            = 32'h0000_0000;
      status_word[ST_A20_BIT]                = !a20_sync_reg;
      status_word[ST_FAULT_BIT]              = !fp_fault_out_n;
      status_word[ST_BUSY_BIT]               = (state_reg != ST_IDLE);
      status_word[ST_WIDTH_LSB +: 2]         = width_code_reg;
      status_word[ST_IGNORE_BIT]             = !fp_fault_ignore_n;
   end

   // axi read path: data one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= AXI_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= AXI_OKAY;
         unique case (s_axi_araddr)
            REG_FP_MASK:  s_axi_rdata <= {{(DATA_W-FP_CLS_W){1'b0}}, fp_mask_reg};
            REG_STATUS:   s_axi_rdata <= status_word;
            REG_IRQ_STAT: s_axi_rdata <= {{(DATA_W-IRQ_W){1'b0}}, irq_stat_reg};
            REG_IRQ_MASK: s_axi_rdata <= {{(DATA_W-IRQ_W){1'b0}}, irq_mask_reg};
            default: begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= AXI_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // checks kept beside the logic
   a_width_every_clk: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> width_pins_reg == $past({width16_req_n, width8_req_n}))
      else $error("width pins not sampled on this edge");

   a_full_width_one: assert property (@(posedge aclk) disable iff (!aresetn)
      bus_ready && offset_reg == 3'h0 && width_pins_reg == 2'h3 |=> resp_valid && state_reg == ST_IDLE)
      else $error("full width cycle did not finish the request");

   a_half_width_split: assert property (@(posedge aclk) disable iff (!aresetn)
      bus_ready && offset_reg == 3'h0 && width_pins_reg == 2'h1
      |=> (!resp_valid && !bus_start_n && offset_reg == 3'h2 && bus_byte_en_n == 4'h3)
      ##2 state_reg == ST_DATA)
      else $error("16-bit target not split into two cycles");

   a_byte_priority: assert property (@(posedge aclk) disable iff (!aresetn)
      bus_ready && offset_reg == 3'h0 && width_pins_reg == 2'h0 |=> offset_reg == 3'h1 && !bus_start_n)
      else $error("both width pins low not taken as 8-bit");

   a_addr_bit_low: assert property (@(posedge aclk) disable iff (!aresetn)
      $fell(bus_start_n) && !$past(a20_sync_reg) |-> !bus_addr[A20_BIT])
      else $error("bus address bit 20 not forced low");

   a_lookup_bit_low: assert property (@(posedge aclk) disable iff (!aresetn)
      lookup_valid && !$past(a20_sync_reg) |-> !lookup_addr[A20_BIT])
      else $error("lookup address bit 20 not forced low");

   a_mask_sync_two: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) && $past(aresetn, 2) |-> a20_sync_reg == $past(addr_bit20_force_low_n, 2))
      else $error("mask input not seen two clocks later");

   a_fault_raise: assert property (@(posedge aclk) disable iff (!aresetn)
      fp_unmasked |=> !fp_fault_out_n ##1 (!fp_fault_out_n || $past(fp_error_clear)))
      else $error("unmasked error did not assert fault output");

   a_fault_masked: assert property (@(posedge aclk) disable iff (!aresetn)
      fp_fault_out_n && fp_error_valid && ((fp_error_class & ~fp_mask_reg) == '0) |=> fp_fault_out_n)
      else $error("masked error asserted fault output");

   a_fault_in_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      !fp_fault_out_n && bus_hold && !fp_error_clear |=> !fp_fault_out_n)
      else $error("fault output dropped during bus hold");

   a_fault_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
      fp_unmasked && !fp_fault_ignore_n |=> !fp_fault_out_n && irq_stat_reg[IRQ_FP_BIT])
      else $error("ignore input suppressed fault output");

   a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> irq == $past(|(irq_stat_reg & irq_mask_reg)))
      else $error("interrupt output does not follow masked status");
endmodule
`default_nettype wire

// File: logic/bsafe_pkg.sv
`default_nettype none
package bsafe_pkg;
   // widths
   localparam int ADDR_W   = 32;
   localparam int DATA_W   = 32;
   localparam int AXI_AW   = 8;
   localparam int FP_CLS_W = 6;
   localparam int IRQ_W    = 2;
   localparam int A20_BIT  = 20;

   // register byte offsets
   localparam logic [AXI_AW-1:0] REG_FP_MASK  = 8'h00;
   localparam logic [AXI_AW-1:0] REG_STATUS   = 8'h04;
   localparam logic [AXI_AW-1:0] REG_IRQ_STAT = 8'h08;
   localparam logic [AXI_AW-1:0] REG_IRQ_MASK = 8'h0C;

   // reset values
   localparam logic [FP_CLS_W-1:0] FP_MASK_RST  = 6'h3F;
   localparam logic [IRQ_W-1:0]    IRQ_MASK_RST = 2'h0;
   localparam logic                A20_SYNC_RST = 1'b1;

   // interrupt status bits
   localparam int IRQ_FP_BIT    = 0;
   localparam int IRQ_SPLIT_BIT = 1;

   // status register bits
   localparam int ST_A20_BIT    = 0;
   localparam int ST_FAULT_BIT  = 1;
   localparam int ST_BUSY_BIT   = 2;
   localparam int ST_WIDTH_LSB  = 3;
   localparam int ST_IGNORE_BIT = 5;

   // transfer sizes in bytes
   localparam logic [2:0] BYTES_8    = 3'h1;
   localparam logic [2:0] BYTES_16   = 3'h2;
   localparam logic [2:0] WORD_BYTES = 3'h4;

   // axi responses
   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;

   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} bsafe_state_type;
endpackage
`default_nettype wire

// File: test/bsafe_target.sv
`timescale 1ns/1ps
`default_nettype none
// stand-in bus target with its ready and sizing logic; answers each bus cycle after a set wait
module bsafe_target (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        bus_start_n,
   input  wire logic [31:0] bus_addr,
   input  wire logic [1:0]  width_cfg,
   input  wire logic [3:0]  wait_cfg,
   output logic [31:0]      bus_rdata,
   output logic             burst_cycle_done_n,
   output logic             width16_req_n,
   output logic             width8_req_n
);
   logic [4:0]  cnt_reg;
   logic [31:0] word;
   // wait counter, loaded by each bus cycle launch
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= 5'h00;
      end else if (!bus_start_n) begin
         cnt_reg <= 5'(wait_cfg) + 5'h02;
      end else if (cnt_reg != 5'h00) begin
         cnt_reg <= cnt_reg - 5'h01;
      end
   end
   // sizing pins hold the true width only in the deciding clock and the ready clock;
   // elsewhere they show the inverse, so sampling at the wrong edge picks a wrong size
   assign width16_req_n = (cnt_reg inside {5'h01, 5'h02}) ? width_cfg[1] : ~width_cfg[1];
   assign width8_req_n  = (cnt_reg inside {5'h01, 5'h02}) ? width_cfg[0] : ~width_cfg[0];
   // ready for one clock; data lines scrambled outside it
   assign burst_cycle_done_n = (cnt_reg != 5'h01);
   assign word               = {bus_addr[31:2], 2'b00} ^ 32'hC3A5_5A3C;
   assign bus_rdata          = burst_cycle_done_n ? ~word : word;
endmodule
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin checks_done++; if ((act) !== (exp)) begin fails++; $display("BAD %0t %h %h", $time, (act), (exp)); end end
module tb_top;
   import bsafe_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, irq;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_awready, s_axi_wvalid = 1'b0, s_axi_wready, s_axi_bvalid, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_arready, s_axi_rvalid, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF, bus_byte_en_n;
   logic [1:0] s_axi_bresp, s_axi_rresp, width_cfg = 2'h3;
   logic [3:0] wait_cfg = 4'h0;
   logic req_valid = 1'b0, req_ready, req_write = 1'b0, resp_valid, lookup_valid, bus_start_n, bus_write;
   logic [31:0] req_addr = 32'h0000_0000, req_wdata = 32'h0000_0000, resp_rdata, lookup_addr;
   logic [31:0] bus_addr, bus_wdata, bus_rdata, lk_addr;
   logic burst_cycle_done_n, width16_req_n, width8_req_n, addr_bit20_force_low_n = 1'b1, bus_hold = 1'b0;
   logic fp_error_valid = 1'b0, fp_error_clear = 1'b0, fp_fault_ignore_n = 1'b1, fp_fault_out_n, seen20;
   logic [5:0] fp_error_class = 6'h00;
   int fails = 0, checks_done = 0, nbus = 0, cyc = 0;
   int ncyc[4] = '{4, 2, 4, 1};

   // 50 mhz clock
   always #10 aclk = ~aclk;

   bsafe_core i_dut (.*);
   bsafe_target i_target (.*);

   // count bus cycle launches and note bit 20 as driven on the bus
   always @(posedge aclk) begin
      if (!bus_start_n) begin
         nbus <= nbus + 1;
         seen20 <= bus_addr[20];
      end
      if (lookup_valid) lk_addr <= lookup_addr;
   end

   // hang guard, well above the expected run length
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         results();
      end
   end

   task automatic results();
      if (fails == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // axi4-lite write; address and data offered together, each released once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_take, w_take;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      @(negedge aclk);
      while (s_axi_awvalid || s_axi_wvalid) begin
         aw_take = s_axi_awready;
         w_take = s_axi_wready;
         @(posedge aclk);
         if (aw_take) s_axi_awvalid <= 1'b0;
         if (w_take) s_axi_wvalid <= 1'b0;
         @(negedge aclk);
      end
      while (s_axi_bvalid !== 1'b1) @(negedge aclk);
      `CHK(s_axi_bresp, er)
      @(posedge aclk);
      s_axi_bready <= 1'b0;
   endtask

   // axi4-lite read, compared under a bit mask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(negedge aclk); while (s_axi_arready !== 1'b1);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
      `CHK(s_axi_rdata & m, e)
      `CHK(s_axi_rresp, er)
      @(posedge aclk);
      s_axi_rready <= 1'b0;
   endtask

   // one core request; checks bus cycle count, masked address and assembled data
   task automatic core_req(input logic [31:0] a, input logic wr, input int n, input logic [31:0] ea);
      @(posedge aclk);
      nbus = 0;
      req_valid <= 1'b1;
      req_addr <= a;
      req_write <= wr;
      req_wdata <= ~a;
      do @(negedge aclk); while (req_ready !== 1'b1);
      @(posedge aclk);
      req_valid <= 1'b0;
      do @(negedge aclk); while (resp_valid !== 1'b1);
      `CHK(nbus, n)
      `CHK(lk_addr, ea)
      `CHK(seen20, ea[20])
      `CHK(bus_byte_en_n, 4'hF)
      `CHK(bus_write, wr)
      if (wr) `CHK(bus_wdata, ~a)
      if (!wr) `CHK(resp_rdata, {ea[31:2], 2'b00} ^ 32'hC3A5_5A3C)
   endtask

   // pulse one numeric error, then look at the fault pin
   task automatic fp_err(input logic [5:0] cls, input logic e);
      @(posedge aclk);
      fp_error_valid <= 1'b1;
      fp_error_class <= cls;
      @(posedge aclk);
      fp_error_valid <= 1'b0;
      repeat (2) @(negedge aclk);
      `CHK(fp_fault_out_n, e)
   endtask

   // main sequence
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(REG_FP_MASK, 32'h0000_003F, 32'hFFFF_FFFF, AXI_OKAY);
      axi_rd(REG_IRQ_MASK, 32'h0000_0000, 32'hFFFF_FFFF, AXI_OKAY);
      axi_rd(8'h10, 32'h0000_0000, 32'hFFFF_FFFF, AXI_SLVERR);
      axi_wr(8'h14, 32'h0000_0001, AXI_SLVERR);
      // a write with the low lane strobe off must leave the mask alone
      s_axi_wstrb <= 4'h0;
      axi_wr(REG_FP_MASK, 32'h0000_0000, AXI_OKAY);
      s_axi_wstrb <= 4'hF;
      axi_rd(REG_FP_MASK, 32'h0000_003F, 32'hFFFF_FFFF, AXI_OKAY);
      for (int i = 0; i < 8; i++) begin
         @(posedge aclk);
         width_cfg <= i[1:0];
         wait_cfg <= i[2] ? 4'h3 : 4'h0;
         core_req(32'h0000_1000 + 32'(i * 4), 1'b0, ncyc[i[1:0]], 32'h0000_1000 + 32'(i * 4));
      end
      core_req(32'h0000_2000, 1'b1, 1, 32'h0000_2000);
      axi_rd(REG_IRQ_STAT, 32'h0000_0002, 32'h0000_0003, AXI_OKAY);
      axi_wr(REG_IRQ_STAT, 32'h0000_0002, AXI_OKAY);
      axi_rd(REG_IRQ_STAT, 32'h0000_0000, 32'h0000_0003, AXI_OKAY);
      addr_bit20_force_low_n <= 1'b0;
      repeat (3) @(posedge aclk);
      core_req(32'h0010_0040, 1'b0, 1, 32'h0000_0040);
      axi_rd(REG_STATUS, 32'h0000_0001, 32'h0000_0001, AXI_OKAY);
      addr_bit20_force_low_n <= 1'b1;
      repeat (3) @(posedge aclk);
      core_req(32'h0010_0040, 1'b0, 1, 32'h0010_0040);
      axi_wr(REG_FP_MASK, 32'h0000_003E, AXI_OKAY);
      axi_wr(REG_IRQ_MASK, 32'h0000_0001, AXI_OKAY);
      fp_err(6'h3E, 1'b1);
      `CHK(irq, 1'b0)
      @(posedge aclk);
      fp_fault_ignore_n <= 1'b0;
      bus_hold <= 1'b1;
      fp_err(6'h01, 1'b0);
      `CHK(irq, 1'b1)
      repeat (4) @(negedge aclk);
      `CHK(fp_fault_out_n, 1'b0)
      axi_rd(REG_STATUS, 32'h0000_003A, 32'h0000_003F, AXI_OKAY);
      @(posedge aclk);
      fp_error_clear <= 1'b1;
      @(posedge aclk);
      fp_error_clear <= 1'b0;
      repeat (2) @(negedge aclk);
      `CHK(fp_fault_out_n, 1'b1)
      axi_rd(REG_IRQ_STAT, 32'h0000_0001, 32'h0000_0003, AXI_OKAY);
      axi_wr(REG_IRQ_STAT, 32'h0000_0001, AXI_OKAY);
      repeat (3) @(negedge aclk);
      `CHK(irq, 1'b0)
      results();
   end
endmodule
`default_nettype wire
